// ### logic/spc_power_ctrl.sv
`include "spc_cfg.svh"

module spc_power_ctrl (
	input  wire logic             i_clk_sys,      // System clock, 10 MHz
	input  wire logic             i_rstn,         // External reset, active low
	input  wire logic             i_ref_tick,     // Slow always-on reference tick
	input  wire logic             i_sfr_wr,       // Register write strobe
	input  wire logic             i_sfr_rd,       // Register read strobe
	input  wire logic [7:0]       i_sfr_addr,     // Register address
	input  wire logic [7:0]       i_sfr_wdata,    // Register write data
	input  wire logic             i_instr_done,   // Current instruction retires
	input  wire logic             i_irq_pending,  // Enabled interrupt pending
	input  wire logic             i_loss_det_en,  // Clock-loss detector enable
	output logic [7:0]            o_sfr_rdata,    // Register read data
	output logic                  o_cpu_clk_en,   // CPU clock enable
	output logic                  o_periph_clk_en,// Peripheral clock enable
	output logic                  o_osc_en,       // Internal oscillator enable
	output logic                  o_loss_rst,     // Internal clock-loss reset pulse
	output logic                  o_core_rstn,    // Core reset, active low
	output logic [15:0]           o_fetch_addr,   // Restart fetch address
	output spc_pkg::spc_state_t   o_state         // Present power state
);
	import spc_pkg::*;

	logic        rst_meta_reg;    // Reset synchroniser, first stage
	logic        rst_sync_reg;    // Reset synchroniser, second stage
	logic        rstn;            // Released reset used by the design
	logic [7:0]  ctrl_reg;        // Stored bits of power control
	logic        stop_req_reg;    // Stop requested, awaiting retirement
	logic        idle_req_reg;    // Idle requested, awaiting retirement
	spc_state_t  state_reg;       // Power state
	spc_state_t  state_next;      // Next power state
	logic [9:0]  loss_cnt_reg;    // Reference ticks seen while stopped
	logic        tick_m_reg;      // Reference tick sync, first stage
	logic        tick_s_reg;      // Reference tick sync, second stage
	logic        tick_d_reg;      // Delayed tick for edge detection
	logic        sel_hit;         // Access addresses the register
	logic        loss_fire;       // Timeout reached

	// Address hit decode shared by the write and read processes
	function automatic logic spc_hit(input logic [7:0] a);
		spc_hit = (a == `SPC_ADDR_POWER_CONTROL);
	endfunction : spc_hit

	assign sel_hit = spc_hit(i_sfr_addr);

	// Reset release through two flip-flops, merged with clock-loss reset
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else if (o_loss_rst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rstn = rst_sync_reg;

	// Stored register bits; select bits are never stored
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `SPC_POWER_CONTROL_RST;
		end else if (i_sfr_wr && sel_hit) begin
			ctrl_reg <= i_sfr_wdata & `SPC_STORED_MASK;
		end
	end

	// Write-one triggers held until the writing instruction retires
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			stop_req_reg <= 1'b0;
			idle_req_reg <= 1'b0;
		end else if (i_sfr_wr && sel_hit) begin
			// Writing zero leaves a pending request alone
			stop_req_reg <= stop_req_reg | i_sfr_wdata[`SPC_BIT_STOP_SEL];
			idle_req_reg <= idle_req_reg | i_sfr_wdata[`SPC_BIT_IDLE_SEL];
		end else if (i_instr_done) begin
			stop_req_reg <= 1'b0;
			idle_req_reg <= 1'b0;
		end
	end

	// Next power state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SPC_RUN: begin
				if (stop_req_reg && i_instr_done) begin
					state_next = SPC_STOP;
				end else if (idle_req_reg && i_instr_done) begin
					state_next = SPC_IDLE;
				end
			end
			SPC_IDLE: begin
				if (i_irq_pending) begin
					state_next = SPC_RUN;
				end
			end
			SPC_STOP: begin
				state_next = SPC_STOP;
			end
			default: begin
				state_next = SPC_RUN;
			end
		endcase
	end

	// State register; only reset leaves stop
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= SPC_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Clock enables and oscillator control
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_cpu_clk_en    <= 1'b1;
			o_periph_clk_en <= 1'b1;
			o_osc_en        <= 1'b1;
		end else begin
			o_cpu_clk_en    <= (state_next == SPC_RUN);
			o_osc_en        <= (state_next != SPC_STOP);
			o_periph_clk_en <= (state_next != SPC_STOP);
		end
	end

	// Reference tick synchroniser; that tick keeps running while stopped
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_m_reg <= 1'b0;
			tick_s_reg <= 1'b0;
			tick_d_reg <= 1'b0;
		end else begin
			tick_m_reg <= i_ref_tick;
			tick_s_reg <= tick_m_reg;
			tick_d_reg <= tick_s_reg;
		end
	end

	assign loss_fire = (loss_cnt_reg == 10'(`SPC_LOSS_TIMEOUT_CYC - 1));

	// Clock-loss timeout counter, armed only in stop with detector on
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			loss_cnt_reg <= 10'h000;
		end else if (state_reg != SPC_STOP || !i_loss_det_en) begin
			loss_cnt_reg <= 10'h000;
		end else if (tick_s_reg && !tick_d_reg && !loss_fire) begin
			loss_cnt_reg <= loss_cnt_reg + 10'h001;
		end
	end

	// Internal reset pulse at timeout
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_loss_rst <= 1'b0;
		end else begin
			o_loss_rst <= loss_fire && (state_reg == SPC_STOP) && i_loss_det_en;
		end
	end

	// Core reset and restart vector
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_core_rstn  <= 1'b0;
			o_fetch_addr <= `SPC_RESET_VECTOR;
		end else begin
			o_core_rstn  <= 1'b1;
			o_fetch_addr <= `SPC_RESET_VECTOR;
		end
	end

	// Read data; select and reserved bits read zero
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr_rd && sel_hit) begin
			o_sfr_rdata <= ctrl_reg & `SPC_STORED_MASK;
		end else begin
			o_sfr_rdata <= 8'h00;
		end
	end

	// State output
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_state <= SPC_RUN;
		end else begin
			o_state <= state_next;
		end
	end

	a_stop_after_done: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(state_reg == SPC_RUN && stop_req_reg && i_instr_done) |=> (state_reg == SPC_STOP))
		else $error("Stop not entered after instruction retired");
	a_no_early_stop: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(state_reg == SPC_RUN && !i_instr_done) |=> (state_reg != SPC_STOP))
		else $error("Stop entered before instruction retired");
	a_stop_clocks_off: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(state_reg == SPC_STOP) |-> (!o_cpu_clk_en && !o_osc_en))
		else $error("CPU or oscillator running in stop");
	a_periph_gated: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(state_reg == SPC_STOP) |-> !o_periph_clk_en)
		else $error("Peripheral clock running in stop");
	a_stop_holds: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(state_reg == SPC_STOP) |=> (state_reg == SPC_STOP))
		else $error("Stop left without reset");
	a_restart_vector: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		$rose(o_core_rstn) |-> (o_fetch_addr == 16'h0000))
		else $error("Restart address not zero");
	a_loss_reset: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(loss_fire && state_reg == SPC_STOP && i_loss_det_en) |=> o_loss_rst)
		else $error("Clock-loss reset missing at timeout");
	a_loss_quiet: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		!i_loss_det_en |=> !o_loss_rst)
		else $error("Clock-loss reset while detector disabled");
	a_select_reads_zero: assert property (@(posedge i_clk_sys) disable iff (!rstn)
		(o_sfr_rdata[1:0] == 2'b00) && (o_sfr_rdata[5] == 1'b0) && (o_sfr_rdata[2] == 1'b0))
		else $error("Select or reserved bits read nonzero");

endmodule : spc_power_ctrl

// ### pkg/spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// Register address of the power control register on the special-function bus
`define SPC_ADDR_POWER_CONTROL 8'h87
// Field positions inside the power control register
`define SPC_BIT_IDLE_SEL       0
`define SPC_BIT_STOP_SEL       1
`define SPC_BIT_UART1_STATSEL  3
`define SPC_BIT_UART1_BAUDX2   4
`define SPC_BIT_UART0_STATSEL  6
`define SPC_BIT_UART0_BAUDX2   7
// Reset value of the register
`define SPC_POWER_CONTROL_RST  8'h00
// Bits that hold storage (baud doublers and status view selects)
`define SPC_STORED_MASK        8'hD8
// Restart address after any reset
`define SPC_RESET_VECTOR       16'h0000
// Clock-loss timeout in microseconds and system clock rate
`define SPC_LOSS_TIMEOUT_US    100
`define SPC_CLK_MHZ            10
// Cycles of the always-on slow reference that make up the timeout
`define SPC_LOSS_TIMEOUT_CYC   (`SPC_LOSS_TIMEOUT_US * `SPC_CLK_MHZ)

`endif

// ### pkg/spc_pkg.sv
package spc_pkg;
	// Power states of the core
	typedef enum logic [2:0] {
		SPC_RUN  = 3'b001,
		SPC_IDLE = 3'b010,
		SPC_STOP = 3'b100
	} spc_state_t;
endpackage : spc_pkg

// ### testbench/spc_power_ctrl_tb.sv
module spc_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spc_pkg::*;

	logic        clk_sys;   // System clock
	logic        rstn;      // External reset, active low
	logic        tick;      // Slow reference tick
	logic        wr;        // Write strobe
	logic        rd;        // Read strobe
	logic [7:0]  addr;      // Register address
	logic [7:0]  wdata;     // Write data
	logic        done;      // Instruction retire pulse
	logic        irq;       // Pending interrupt
	logic        det_en;    // Clock-loss detector enable
	logic [7:0]  rdata;     // Read data
	logic        cpu_en;    // CPU clock enable
	logic        per_en;    // Peripheral clock enable
	logic        osc_en;    // Oscillator enable
	logic        loss_rst;  // Clock-loss reset pulse
	logic        core_rstn; // Core reset, active low
	logic [15:0] fetch;     // Restart fetch address
	spc_state_t  state;     // Power state
	int          err_count; // Mismatches
	int          n_tests;   // Comparisons
	bit          seen;      // Loss pulse observed

	spc_power_ctrl spc_power_ctrl_inst (
		.i_clk_sys(clk_sys), .i_rstn(rstn), .i_ref_tick(tick), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_instr_done(done),
		.i_irq_pending(irq), .i_loss_det_en(det_en), .o_sfr_rdata(rdata),
		.o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_osc_en(osc_en),
		.o_loss_rst(loss_rst), .o_core_rstn(core_rstn), .o_fetch_addr(fetch),
		.o_state(state)
	);

	// 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// Generic value comparison
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Power state and clock enables, ordered CPU, peripheral, oscillator
	task automatic chk_pwr(input spc_state_t st, input logic [2:0] en);
		chk("state", {13'h0000, st}, {13'h0000, state});
		chk("clk_en", {13'h0000, en}, {13'h0000, cpu_en, per_en, osc_en});
	endtask : chk_pwr

	// One-cycle register write
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg

	// Register read, data checked the cycle after the strobe is taken
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, exp}, {8'h00, rdata});
	endtask : rd_chk

	// Retire one instruction
	task automatic retire;
		@(posedge clk_sys);
		done <= 1'b1;
		@(posedge clk_sys);
		done <= 1'b0;
		#1;
	endtask : retire

	// Pulse external reset, then allow the release synchroniser to finish
	task automatic ext_reset(input int n);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (n) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : ext_reset

	// Toggle reference ticks for a bounded number of cycles
	task automatic run_ticks(input int cycles, input bit stop_on_loss);
		seen = 1'b0;
		for (int i = 0; i < cycles; i++) begin
			@(posedge clk_sys);
			tick <= i[1];
			#1;
			if (loss_rst === 1'b1) seen = 1'b1;
			if (seen && stop_on_loss) break;
		end
	endtask : run_ticks

	// Main sequence
	initial begin
		{rstn, tick, wr, rd, done, irq, det_en} = 7'h00;
		{addr, wdata} = 16'h0000;
		err_count = 0;
		n_tests = 0;
		ext_reset(8);
		chk("core_rstn", 16'h0001, {15'h0000, core_rstn});
		chk("fetch", 16'h0000, fetch);
		chk_pwr(SPC_RUN, 3'h7);
		rd_chk(8'h87, 8'h00);
		wr_reg(8'h87, 8'hFC);
		rd_chk(8'h87, 8'hD8);
		wr_reg(8'h80, 8'h02);
		retire();
		chk_pwr(SPC_RUN, 3'h7);
		rd_chk(8'h80, 8'h00);
		wr_reg(8'h87, 8'h00);
		retire();
		chk_pwr(SPC_RUN, 3'h7);
		// Idle request: only the CPU clock stops, an interrupt wakes it
		wr_reg(8'h87, 8'h01);
		retire();
		chk_pwr(SPC_IDLE, 3'h3);
		@(posedge clk_sys);
		irq <= 1'b1;
		@(posedge clk_sys);
		irq <= 1'b0;
		#1;
		chk_pwr(SPC_RUN, 3'h7);
		// No analog peripheral hangs off this block, so none to switch off
		wr_reg(8'h87, 8'h02);
		repeat (3) @(posedge clk_sys);
		#1;
		chk_pwr(SPC_RUN, 3'h7);
		retire();
		chk_pwr(SPC_STOP, 3'h0);
		irq <= 1'b1;
		retire();
		repeat (4) @(posedge clk_sys);
		#1;
		chk_pwr(SPC_STOP, 3'h0);
		irq <= 1'b0;
		ext_reset(3);
		chk_pwr(SPC_RUN, 3'h7);
		chk("fetch", 16'h0000, fetch);
		// Both selects written together: stop takes precedence over idle
		wr_reg(8'h87, 8'hDB);
		retire();
		chk_pwr(SPC_STOP, 3'h0);
		// Long stop with the detector switched off beforehand
		run_ticks(4400, 1'b0);
		chk("no_loss", 16'h0000, {15'h0000, seen});
		chk_pwr(SPC_STOP, 3'h0);
		det_en <= 1'b1;
		run_ticks(4600, 1'b1);
		chk("loss_rst", 16'h0001, {15'h0000, seen});
		if (!seen) stop_test();
		det_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk_pwr(SPC_RUN, 3'h7);
		chk("core_rstn", 16'h0001, {15'h0000, core_rstn});
		chk("fetch", 16'h0000, fetch);
		rd_chk(8'h87, 8'h00);
		stop_test();
	end
endmodule : spc_power_ctrl_tb
